// File: hdl/cantx_mailbox.sv
// One transmit mailbox: pending state, outcome flags and abort request
`timescale 1ns/1ps
module cantx_mailbox
  import cantx_pkg::*;
(
  input  wire logic       i_mclk,       // Clock
  input  wire logic       i_rst_n,      // Async reset, active low
  input  wire logic       i_req,        // New transmit request accepted
  input  wire logic       i_start,      // Engine starts sending this mailbox
  input  wire logic       i_ok,         // Attempt succeeded
  input  wire logic       i_arb,        // Attempt lost arbitration
  input  wire logic       i_err,        // Attempt failed on error
  input  wire cantx_w1c_t i_w1c,        // Software clear strobes
  input  wire logic       i_abort_set,  // Software abort strobe
  output logic            o_done,       // Request done flag
  output logic            o_ok,         // Send ok flag
  output logic            o_arb,        // Arbitration lost flag
  output logic            o_err,        // Send error flag
  output logic            o_abort,      // Abort request flag
  output logic            o_pending,    // Message waiting to send
  output logic            o_done_evt,   // Done flag sets this cycle
  output logic            o_fail_evt    // Attempt failed this cycle
);
  logic busy_q;
  logic fail;
  logic drop;
  logic finish;

  // Outcome decode; an idle aborted message leaves at once
  assign fail       = busy_q & (i_arb | i_err);
  assign drop       = o_pending & o_abort & ~busy_q & ~i_start;
  assign finish     = (busy_q & i_ok) | (fail & o_abort) | drop;
  assign o_done_evt = finish;
  assign o_fail_evt = fail;

  // Pending message and in-flight state
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pending <= 1'b0;
      busy_q    <= 1'b0;
    end else begin
      if (finish) begin
        o_pending <= 1'b0;
      end else if (i_req) begin
        o_pending <= 1'b1;
      end
      if (i_start && o_pending) begin
        busy_q <= 1'b1;
      end else if (busy_q && (i_ok || i_arb || i_err)) begin
        busy_q <= 1'b0;
      end
    end
  end

  // Request done: cleared by software or new request, set wins
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_done <= 1'b0;
    end else if (finish) begin
      o_done <= 1'b1;
    end else if (i_req || i_w1c[0]) begin
      o_done <= 1'b0;
    end
  end

  // Success flag: zero after a failed or dropped attempt
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ok <= 1'b0;
    end else if (busy_q && i_ok) begin
      o_ok <= 1'b1;
    end else if (fail || drop || i_w1c[1]) begin
      o_ok <= 1'b0;
    end
  end

  // Arbitration lost and error flags
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_arb <= 1'b0;
      o_err <= 1'b0;
    end else begin
      if (busy_q && i_arb) begin
        o_arb <= 1'b1;
      end else if (i_w1c[2]) begin
        o_arb <= 1'b0;
      end
      if (busy_q && i_err) begin
        o_err <= 1'b1;
      end else if (i_w1c[3]) begin
        o_err <= 1'b0;
      end
    end
  end

  // Abort request: takes only on a pending message, hardware clears it
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_abort <= 1'b0;
    end else if (finish || !o_pending) begin
      o_abort <= 1'b0;
    end else if (i_abort_set && !(busy_q && i_ok)) begin
      o_abort <= 1'b1;
    end
  end
endmodule // cantx_mailbox

// File: hdl/cantx_params.svh
// Offsets, field positions, reset values and map of the transmit status block
`ifndef CANTX_PARAMS_SVH
`define CANTX_PARAMS_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define CANTX_OFS_TXSTS     12'h008
`define CANTX_OFS_IRQ_STAT  12'h020
`define CANTX_OFS_IRQ_CLR   12'h024
`define CANTX_OFS_IRQ_EN    12'h028
`define CANTX_ADDR_W        12

// ==========================================================================
// Transmit status word layout
`define CANTX_MB_STRIDE     8
`define CANTX_POS_DONE      0
`define CANTX_POS_OK        1
`define CANTX_POS_ARB       2
`define CANTX_POS_ERR       3
`define CANTX_POS_ABORT     7
`define CANTX_POS_FREE      24
`define CANTX_POS_EMPTY     26
`define CANTX_POS_LOWP      29
`define CANTX_TXSTS_RESET   32'h1C000000

// ==========================================================================
// Interrupt status layout: done events, then failure events
`define CANTX_IRQ_POS_DONE  0
`define CANTX_IRQ_POS_FAIL  3
`define CANTX_IRQ_W         6

`endif

// File: hdl/cantx_pkg.sv
// Types shared by the transmit status block
package cantx_pkg;
  typedef logic [1:0]  cantx_mbnum_t;   // Mailbox number
  typedef logic [31:0] cantx_word_t;    // Bus data word
  typedef logic [3:0]  cantx_w1c_t;     // Done, ok, arb, err clear strobes
endpackage

// File: hdl/cantx_status.sv
// Transmit status register block for three CAN transmit mailboxes
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`include "cantx_params.svh"
module cantx_status
  import cantx_pkg::*;
#(
  parameter int PRIO_W = 29                        // Width of a priority key
)(
  input  wire logic                  i_mclk,       // Clock, 50 MHz
  input  wire logic                  i_rst_n,      // Async reset, active low
  // APB slave
  input  wire logic                  i_psel,       // Select
  input  wire logic                  i_penable,    // Access phase
  input  wire logic                  i_pwrite,     // Write direction
  input  wire logic [11:0]           i_paddr,      // Byte address
  input  wire logic [31:0]           i_pwdata,     // Write data
  output logic      [31:0]           o_prdata,     // Read data
  output logic                       o_pready,     // Transfer ready
  output logic                       o_pslverr,    // Unmapped address
  // Protocol engine side, one bit or one PRIO_W-bit key per mailbox
  input  wire logic [2:0]            i_tx_req,     // Transmit request accepted
  input  wire logic [2:0]            i_tx_start,   // Attempt begins
  input  wire logic [2:0]            i_tx_ok,      // Attempt succeeded
  input  wire logic [2:0]            i_tx_arb,     // Attempt lost arbitration
  input  wire logic [2:0]            i_tx_err,     // Attempt failed on error
  input  wire logic [3*PRIO_W-1:0]   i_prio_key,   // Keys, lower value wins
  output logic      [2:0]            o_mb_pending, // Message waiting per mailbox
  output logic                       o_irq         // Interrupt, active high
);

  // ========================================================================
  // Bus decode
  logic       acc;
  logic       wr;
  logic       sel_txsts;
  logic       sel_istat;
  logic       sel_iclr;
  logic       sel_ien;
  logic       mapped;

  assign acc       = i_psel & i_penable & o_pready;
  assign wr        = acc & i_pwrite;
  assign sel_txsts = (i_paddr == `CANTX_OFS_TXSTS);
  assign sel_istat = (i_paddr == `CANTX_OFS_IRQ_STAT);
  assign sel_iclr  = (i_paddr == `CANTX_OFS_IRQ_CLR);
  assign sel_ien   = (i_paddr == `CANTX_OFS_IRQ_EN);
  assign mapped    = sel_txsts | sel_istat | sel_iclr | sel_ien;

  // ========================================================================
  // Mailboxes
  logic [2:0] done;
  logic [2:0] ok;
  logic [2:0] arb;
  logic [2:0] err;
  logic [2:0] abort;
  logic [2:0] pending;
  logic [2:0] done_evt;
  logic [2:0] fail_evt;

  for (genvar m = 0; m < 3; m++) begin : g_mb
    cantx_w1c_t w1c;
    logic       abort_set;

    // Write-one strobes for this mailbox byte
    assign w1c[0] = wr & sel_txsts & i_pwdata[m*`CANTX_MB_STRIDE + `CANTX_POS_DONE];
    assign w1c[1] = wr & sel_txsts & i_pwdata[m*`CANTX_MB_STRIDE + `CANTX_POS_OK];
    assign w1c[2] = wr & sel_txsts & i_pwdata[m*`CANTX_MB_STRIDE + `CANTX_POS_ARB];
    assign w1c[3] = wr & sel_txsts & i_pwdata[m*`CANTX_MB_STRIDE + `CANTX_POS_ERR];
    assign abort_set = wr & sel_txsts
                     & i_pwdata[m*`CANTX_MB_STRIDE + `CANTX_POS_ABORT];

    cantx_mailbox u_mb (
      .i_mclk      (i_mclk),
      .i_rst_n     (i_rst_n),
      .i_req       (i_tx_req[m]),
      .i_start     (i_tx_start[m]),
      .i_ok        (i_tx_ok[m]),
      .i_arb       (i_tx_arb[m]),
      .i_err       (i_tx_err[m]),
      .i_w1c       (w1c),
      .i_abort_set (abort_set),
      .o_done      (done[m]),
      .o_ok        (ok[m]),
      .o_arb       (arb[m]),
      .o_err       (err[m]),
      .o_abort     (abort[m]),
      .o_pending   (pending[m]),
      .o_done_evt  (done_evt[m]),
      .o_fail_evt  (fail_evt[m])
    );
  end

  assign o_mb_pending = pending;

  // ========================================================================
  // Free mailbox code: lowest-numbered empty mailbox, zero when all full
  cantx_mbnum_t free_code;

  always_comb begin
    free_code = 2'h0;
    if (!pending[0]) begin
      free_code = 2'h0;
    end else if (!pending[1]) begin
      free_code = 2'h1;
    end else if (!pending[2]) begin
      free_code = 2'h2;
    end
  end

  // ========================================================================
  // Least priority among pending mailboxes, flagged only when two or more are pending; ties go to the higher number
  logic [2:0] lowp;
  logic [1:0] npend;

  assign npend = 2'(pending[0]) + 2'(pending[1]) + 2'(pending[2]);

  always_comb begin
    logic [PRIO_W-1:0] km;
    logic [PRIO_W-1:0] kk;
    km = '0;
    kk = '0;
    lowp = 3'h0;
    for (int m = 0; m < 3; m++) begin
      km = i_prio_key[m*PRIO_W +: PRIO_W];
      lowp[m] = pending[m] && (npend > 2'h1);
      for (int k = 0; k < 3; k++) begin
        kk = i_prio_key[k*PRIO_W +: PRIO_W];
        if (k != m && pending[k]) begin
          if (km < kk || (km == kk && m < k)) begin
            lowp[m] = 1'b0;
          end
        end
      end
    end
  end

  // ========================================================================
  // Transmit status word; reserved positions stay zero
  cantx_word_t txsts;

  always_comb begin
    txsts = 32'h00000000;
    for (int m = 0; m < 3; m++) begin
      txsts[m*`CANTX_MB_STRIDE + `CANTX_POS_DONE]  = done[m];
      txsts[m*`CANTX_MB_STRIDE + `CANTX_POS_OK]    = ok[m];
      txsts[m*`CANTX_MB_STRIDE + `CANTX_POS_ARB]   = arb[m];
      txsts[m*`CANTX_MB_STRIDE + `CANTX_POS_ERR]   = err[m];
      txsts[m*`CANTX_MB_STRIDE + `CANTX_POS_ABORT] = abort[m];
    end
    txsts[`CANTX_POS_FREE +: 2]  = free_code;
    txsts[`CANTX_POS_EMPTY +: 3] = ~pending;
    txsts[`CANTX_POS_LOWP +: 3]  = lowp;
  end

  // ========================================================================
  // Interrupt status, enable and output
  logic [`CANTX_IRQ_W-1:0] istat_q;
  logic [`CANTX_IRQ_W-1:0] ien_q;
  logic [`CANTX_IRQ_W-1:0] iset;
  logic [`CANTX_IRQ_W-1:0] iclr;

  assign iset = {fail_evt, done_evt};
  assign iclr = (wr && sel_iclr) ? i_pwdata[`CANTX_IRQ_W-1:0] : '0;

  // Sticky events; a new event beats a clear in the same cycle
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      istat_q <= '0;
    end else begin
      istat_q <= (istat_q & ~iclr) | iset;
    end
  end

  // Interrupt enable register
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ien_q <= '0;
    end else if (wr && sel_ien) begin
      ien_q <= i_pwdata[`CANTX_IRQ_W-1:0];
    end
  end

  // Level interrupt from enabled status bits
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(((istat_q & ~iclr) | iset) & ien_q);
    end
  end

  // ========================================================================
  // APB answer: ready in the first access cycle, data captured in setup
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & ~mapped;
    end
  end

  // Read data; clear register reads as zero
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h00000000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      if (sel_txsts) begin
        o_prdata <= txsts;
      end else if (sel_istat) begin
        o_prdata <= {{(32-`CANTX_IRQ_W){1'b0}}, istat_q};
      end else if (sel_ien) begin
        o_prdata <= {{(32-`CANTX_IRQ_W){1'b0}}, ien_q};
      end else begin
        o_prdata <= 32'h00000000;
      end
    end
  end

endmodule // cantx_status

// File: testbench/cantx_chk.sv
// Port checker of the transmit status block
`timescale 1ns/1ps
`include "cantx_params.svh"
module cantx_chk
  import cantx_pkg::*;
(
  input wire logic        i_mclk,      // Clock
  input wire logic        i_rst_n,     // Reset, active low
  input wire logic        i_psel,      // Select
  input wire logic        i_penable,   // Access phase
  input wire logic        i_pwrite,    // Write
  input wire logic [11:0] i_paddr,     // Address
  input wire logic [2:0]  i_tx_req,    // Requests
  input wire logic [31:0] o_prdata,    // Read data
  input wire logic        o_pready,    // Ready
  input wire logic        o_pslverr,   // Error
  input wire logic [2:0]  o_mb_pending // Pending
);
  // ====
  // Helpers
  logic [2:0] pend_q; // Pending when the read was set up
  logic [1:0] free;   // Expected free code
  logic       rd;     // Status read completes
  logic       hit;    // Mapped address
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // Pending one cycle back
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) pend_q <= 3'h0;
    else pend_q <= o_mb_pending;
  end
  // Decodes
  assign rd = o_pready && !i_pwrite && i_paddr == `CANTX_OFS_TXSTS;
  assign hit = i_paddr inside {`CANTX_OFS_TXSTS, `CANTX_OFS_IRQ_STAT, `CANTX_OFS_IRQ_CLR,
                               `CANTX_OFS_IRQ_EN};
  assign free = !pend_q[0] ? 2'h0 : !pend_q[1] ? 2'h1 : !pend_q[2] ? 2'h2 : 2'h0;
  // ====
  // Properties
  property p_ready; i_psel && !i_penable |=> o_pready; endproperty
  a_ready: assert property (p_ready) else $error("ready missing after setup");
  property p_slverr; i_psel && !i_penable |=> o_pslverr == !hit; endproperty
  a_slverr: assert property (p_slverr) else $error("slave error wrong");
  property p_resv; rd |-> (o_prdata & 32'h0070_7070) == 32'h0; endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");
  property p_pend; |i_tx_req |=> (o_mb_pending & $past(i_tx_req)) == $past(i_tx_req); endproperty
  a_pend: assert property (p_pend) else $error("request not pending");
  property p_empty; rd |-> o_prdata[28:26] == ~pend_q; endproperty
  a_empty: assert property (p_empty) else $error("empty flags wrong");
  property p_free; rd && pend_q != 3'h7 |-> o_prdata[25:24] == free; endproperty
  a_free: assert property (p_free) else $error("free code wrong");
  property p_single; rd && $onehot(pend_q) |-> o_prdata[31:29] == 3'h0; endproperty
  a_single: assert property (p_single) else $error("priority flag with one pending");
  property p_lowp;
    rd |-> (o_prdata[31:29] & ~pend_q) == 3'h0 && (pend_q != 3'h7 || $onehot(o_prdata[31:29]));
  endproperty
  a_lowp: assert property (p_lowp) else $error("least priority flags wrong");
endmodule // cantx_chk

// File: testbench/cantx_eng_model.sv
// Behavioural protocol engine driving the mailbox attempt pulses
`timescale 1ns/1ps
module cantx_eng_model
  import cantx_pkg::*;
(
  input  wire logic       i_mclk,     // Clock
  output logic      [2:0] o_tx_req,   // Request accepted
  output logic      [2:0] o_tx_start, // Attempt begins
  output logic      [2:0] o_tx_ok,    // Succeeded
  output logic      [2:0] o_tx_arb,   // Lost arbitration
  output logic      [2:0] o_tx_err    // Failed on error
);
  logic [2:0] ev [5]; // Pulse lines: req, start, ok, arb, err
  assign o_tx_req = ev[0];
  assign o_tx_start = ev[1];
  assign o_tx_ok = ev[2];
  assign o_tx_arb = ev[3];
  assign o_tx_err = ev[4];
  // Lines idle from time zero
  initial begin
    for (int k = 0; k < 5; k++) ev[k] = 3'h0;
  end
  // One-cycle pulse on line k of mailbox mb, then a gap
  task automatic hit(input int k, input int mb, input int gap);
    @(posedge i_mclk);
    ev[k][mb] <= 1'b1;
    @(posedge i_mclk);
    ev[k][mb] <= 1'b0;
    repeat (gap) @(posedge i_mclk);
  endtask
  // Request (unless a retry), start, then outcome 0 ok, 1 arb, 2 err
  task automatic send(input int mb, input int res, input int gap, input bit fresh);
    if (fresh) hit(0, mb, gap);
    hit(1, mb, gap);
    hit(2 + res, mb, gap);
  endtask
endmodule // cantx_eng_model

// File: testbench/tb_top.sv
// Self-checking bench of the transmit status block
`timescale 1ns/1ps
`include "cantx_params.svh"
module tb_top;
  import cantx_pkg::*;
  localparam int PW = 4; // Short keys make ties common
  logic            mclk = 1'b0;
  logic            rst_n = 1'b0;
  logic            psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq, serr;
  logic [11:0]     paddr = 12'h0;
  logic [31:0]     pwdata = 32'h0, prdata;
  logic [2:0]      req, start, ok, arb, err, pend, p;
  logic [23:0]     f;
  logic [3*PW-1:0] key = '0;
  cantx_word_t     rd;
  int              fails = 0, samples_checked = 0, cyc = 0, seed = 4, g;
  always #10 mclk = ~mclk;
  cantx_status #(.PRIO_W(PW)) u_dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_tx_req(req),
    .i_tx_start(start), .i_tx_ok(ok), .i_tx_arb(arb), .i_tx_err(err), .i_prio_key(key),
    .o_mb_pending(pend), .o_irq(irq));
  cantx_eng_model u_eng (.i_mclk(mclk), .o_tx_req(req), .o_tx_start(start), .o_tx_ok(ok),
    .o_tx_arb(arb), .o_tx_err(err));
  // Verdict and end of run
  task automatic final_report();
    if (fails == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One comparison
  task automatic chk(string nm, logic [31:0] e, logic [31:0] v);
    samples_checked++;
    if (v !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, v);
    end
  endtask
  // One APB transfer; waits for ready, the hang guard ends a stuck wait
  task automatic apb(bit w, logic [11:0] a, logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Read once state has settled, then compare
  task automatic rchk(string nm, logic [11:0] a, logic [31:0] e);
    repeat (2) @(posedge mclk);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  // Expected status word from pending set, flag bytes and keys
  function automatic logic [31:0] sts(logic [2:0] pp, logic [23:0] ff, logic [3*PW-1:0] k);
    logic [2:0] lp;
    int w;
    lp = 3'h0;
    w = -1;
    for (int m = 0; m < 3; m++)
      if (pp[m] && (w < 0 || k[m*PW+:PW] >= k[w*PW+:PW])) w = m;
    if ($countones(pp) > 1) lp[w] = 1'b1;
    return {lp, ~pp, (!pp[0] ? 2'h0 : !pp[1] ? 2'h1 : !pp[2] ? 2'h2 : 2'h0), ff};
  endfunction
  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end
  // ====
  // Scenarios
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    rchk("reset", `CANTX_OFS_TXSTS, 32'h1C00_0000);
    rchk("unmapped", 12'h0FC, 32'h0);
    chk("slverr", 32'h1, {31'h0, serr});
    apb(1'b1, `CANTX_OFS_TXSTS, 32'hFFFF_FFFF);
    rchk("idle abort", `CANTX_OFS_TXSTS, 32'h1C00_0000);
    apb(1'b1, `CANTX_OFS_IRQ_EN, 32'h0000_003F);
    u_eng.send(0, 0, 1, 1'b1);
    rchk("sent", `CANTX_OFS_TXSTS, 32'h1C00_0003);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, `CANTX_OFS_IRQ_EN, 32'h0);
    apb(1'b1, `CANTX_OFS_TXSTS, 32'h0);
    rchk("write zero", `CANTX_OFS_TXSTS, 32'h1C00_0003);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, `CANTX_OFS_IRQ_CLR, 32'h0000_003F);
    apb(1'b1, `CANTX_OFS_IRQ_EN, 32'h0000_003F);
    rchk("irq clear", `CANTX_OFS_IRQ_STAT, 32'h0);
    chk("irq off", 32'h0, {31'h0, irq});
    apb(1'b1, `CANTX_OFS_TXSTS, 32'h0000_0003);
    f = 24'h0;
    for (int m = 0; m < 3; m++)
      for (int r = 1; r < 3; r++) begin
        g = $unsigned($random(seed)) % 4;
        f &= ~(24'hFF << (8 * m));
        u_eng.send(m, r, g, 1'b1);
        f |= 24'h1 << (8 * m + 1 + r);
        rchk("failed", `CANTX_OFS_TXSTS, sts(3'h1 << m, f, key));
        u_eng.send(m, 0, g, 1'b0);
        f |= 24'h3 << (8 * m);
        rchk("retried", `CANTX_OFS_TXSTS, sts(3'h0, f, key));
        apb(1'b1, `CANTX_OFS_TXSTS, 32'hE << (8 * m));
        f &= ~(24'hE << (8 * m));
      end
    p = 3'h0;
    for (int m = 0; m < 3; m++) begin
      u_eng.hit(0, m, 0);
      p[m] = 1'b1;
      f[8*m] = 1'b0;
      repeat (4) begin
        key <= (3*PW)'($random(seed));
        @(posedge mclk);
        rchk("priority", `CANTX_OFS_TXSTS, sts(p, f, key));
      end
    end
    apb(1'b1, `CANTX_OFS_TXSTS, 32'h0080_8080);
    rchk("abort", `CANTX_OFS_TXSTS, sts(3'h0, 24'h01_0101, key));
    apb(1'b1, `CANTX_OFS_IRQ_CLR, 32'h0000_003F);
    u_eng.hit(0, 1, 0);
    u_eng.hit(1, 1, 0);
    apb(1'b1, `CANTX_OFS_TXSTS, 32'h0000_8000);
    rchk("abort wait", `CANTX_OFS_TXSTS, sts(3'h2, 24'h01_8001, key));
    u_eng.hit(4, 1, 0);
    rchk("abort fail", `CANTX_OFS_TXSTS, sts(3'h0, 24'h01_0901, key));
    rchk("irq events", `CANTX_OFS_IRQ_STAT, 32'h0000_0012);
    chk("irq fail", 32'h1, {31'h0, irq});
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rchk("second reset", `CANTX_OFS_TXSTS, 32'h1C00_0000);
    final_report();
  end
endmodule // tb_top
bind cantx_status cantx_chk u_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_tx_req(i_tx_req),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_mb_pending(o_mb_pending));
